/* File: rtl/apm_defs.svh */
`ifndef APM_DEFS_SVH
`define APM_DEFS_SVH
// Serial-clock falling-edge thresholds
`define APM_EDGE_GLITCH 5'h02
`define APM_EDGE_KEEP 5'h0A
`define APM_EDGE_TH_TRACK 5'h0D
`define APM_EDGE_FRAME 5'h10
// Result width and leading zeros
`define APM_RES_W 12
`define APM_LEAD_ZEROS 4
// Power-up time in ns and its cycle count at 10 ns
`define APM_PWRUP_NS 1000
`define APM_CLK_NS 10
`define APM_PWRUP_CYC ((`APM_PWRUP_NS + `APM_CLK_NS - 1) / `APM_CLK_NS)
// Quiet time in ns and cycles
`define APM_QUIET_NS 60
`define APM_QUIET_CYC ((`APM_QUIET_NS + `APM_CLK_NS - 1) / `APM_CLK_NS)
// Host serial-clock half period in mclk cycles, less one
`define APM_SCLK_HALF 8'h06
`endif

/* File: rtl/apm_pkg.sv */
package apm_pkg;
  typedef enum logic [1:0] {APM_NORMAL, APM_POWER_DOWN, APM_POWERING_UP}
    apm_power_t;
  typedef enum logic [2:0] {APM_H_IDLE, APM_H_LEAD, APM_H_LOW, APM_H_HIGH,
    APM_H_QUIET} apm_host_state_t;
endpackage : apm_pkg

/* File: rtl/apm_link_if.sv */
`timescale 1ns/1ps
interface apm_link_if;
  logic cs_n;
  logic sclk;
  logic serial_out;
  logic serial_out_oe;
  modport device (
    input cs_n,
    input sclk,
    output serial_out,
    output serial_out_oe
  );
  modport host (
    output cs_n,
    output sclk,
    input serial_out,
    input serial_out_oe
  );
endinterface : apm_link_if

/* File: rtl/apm_sync.sv */
`timescale 1ns/1ps
module apm_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Raw pin and cleaned result
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_level;

  // A change is taken only once the second and third stages agree
  always_comb begin
    next_stage = {stage[1:0], pin};
    next_level = level;
    if (stage[2] == stage[1]) begin
      next_level = stage[2];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= 3'h7;
      level <= 1'b1;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

  assign rise = next_level & ~level;
  assign fall = ~next_level & level;
endmodule : apm_sync

/* File: rtl/apm_device.sv */
`timescale 1ns/1ps
`include "apm_defs.svh"
module apm_device (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Link
  apm_link_if.device link,
  // Converter side
  input wire logic [`APM_RES_W-1:0] sample,
  input wire logic start_powered,
  output logic powered,
  output logic analog_on,
  output logic tracking,
  output logic result_valid,
  output logic [`APM_RES_W-1:0] result_word
);
  logic cs_lvl, cs_rise, cs_fall, sck_rise, sck_fall;
  logic next_powered;
  logic started, next_started, pwr_done, next_pwr_done;
  logic was_down, next_was_down, so_oe, next_so_oe, so_bit, next_so_bit;
  logic next_analog_on, next_tracking, next_result_valid;
  logic [4:0] edges, next_edges;
  logic [15:0] shreg, next_shreg;
  logic [`APM_RES_W-1:0] next_result_word;
  logic [7:0] pwr_cnt, next_pwr_cnt;
  apm_pkg::apm_power_t mode, next_mode;

  // Both pins idle high, so the synchronisers reset high and no false
  // edge follows reset
  apm_sync u_cs (.mclk(mclk), .rst_n(rst_n), .pin(link.cs_n),
    .level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
  apm_sync u_sck (.mclk(mclk), .rst_n(rst_n), .pin(link.sclk),
    .level(), .rise(sck_rise), .fall(sck_fall));

  // Fall count once one more serial-clock fall is taken
  function automatic logic [4:0] bump(input logic [4:0] n);
    return n + 5'h01;
  endfunction : bump

  // Rise of select picks the power state from the falls counted so far
  function automatic apm_pkg::apm_power_t pick_mode(
    input apm_pkg::apm_power_t cur,
    input logic [4:0] n
  );
    pick_mode = cur;
    if (n < `APM_EDGE_GLITCH) begin
      // Glitch: a waking device drops back, a powered one stays up
      if (cur == apm_pkg::APM_POWERING_UP) begin
        pick_mode = apm_pkg::APM_POWER_DOWN;
      end
    end else if (n < `APM_EDGE_KEEP) begin
      pick_mode = apm_pkg::APM_POWER_DOWN;
    end else begin
      pick_mode = apm_pkg::APM_NORMAL;
    end
  endfunction : pick_mode

  always_comb begin
    next_mode = mode;
    next_edges = edges;
    next_shreg = shreg;
    next_so_oe = so_oe;
    next_so_bit = so_bit;
    next_tracking = tracking;
    next_result_valid = 1'b0;
    next_result_word = result_word;
    next_was_down = was_down;
    next_pwr_cnt = pwr_cnt;
    next_pwr_done = pwr_done;
    next_started = started;
    // Power-on mode is taken from a strap after reset release
    if (!started) begin
      next_started = 1'b1;
      next_mode = start_powered ? apm_pkg::APM_NORMAL
                                : apm_pkg::APM_POWER_DOWN;
    end else if (cs_fall) begin
      next_edges = 5'h00;
      next_shreg = {`APM_LEAD_ZEROS'(0), sample};
      // Output leaves high impedance showing the first leading zero
      next_so_oe = 1'b1;
      next_so_bit = 1'b0;
      // A frame begun outside normal mode is the wake frame: no result
      next_was_down = (mode != apm_pkg::APM_NORMAL);
      next_pwr_cnt = 8'h00;
      next_pwr_done = 1'b0;
      if (mode != apm_pkg::APM_NORMAL) begin
        next_mode = apm_pkg::APM_POWERING_UP;
      end else begin
        next_tracking = 1'b0;
      end
    end else if (cs_rise) begin
      next_so_oe = 1'b0;
      next_mode = pick_mode(mode, edges);
      if (next_mode == apm_pkg::APM_POWER_DOWN) begin
        next_tracking = 1'b0;
      end else begin
        next_tracking = 1'b1;
      end
    end else if (!cs_lvl) begin
      if (mode == apm_pkg::APM_POWERING_UP) begin
        // Counts only while select stays low; each select fall restarts it
        if (pwr_cnt != 8'(`APM_PWRUP_CYC)) begin
          next_pwr_cnt = pwr_cnt + 8'h01;
        end else begin
          next_pwr_done = 1'b1;
        end
      end
      if ((sck_rise || sck_fall) && was_down && edges == 5'h00) begin
        next_tracking = 1'b1;
      end
      if (sck_fall && edges != `APM_EDGE_FRAME) begin
        next_edges = bump(edges);
        next_shreg = {shreg[14:0], 1'b0};
        next_so_bit = shreg[14];
        // Back to track after the thirteenth fall, ready for the next
        // sample while the last bits still shift out
        if (bump(edges) == `APM_EDGE_TH_TRACK) begin
          next_tracking = 1'b1;
        end
        if (bump(edges) == `APM_EDGE_FRAME) begin
          next_so_oe = 1'b0;
          next_result_word = sample;
          next_result_valid = !was_down;
        end
      end
    end
  end

  // Analog power follows mode; off in power-down
  always_comb begin
    next_analog_on = (next_mode != apm_pkg::APM_POWER_DOWN);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= apm_pkg::APM_NORMAL;
      started <= 1'b0;
      edges <= 5'h00;
      shreg <= 16'h0000;
      so_oe <= 1'b0;
      so_bit <= 1'b0;
      tracking <= 1'b1;
      analog_on <= 1'b0;
      result_valid <= 1'b0;
      result_word <= 12'h000;
      was_down <= 1'b0;
      pwr_cnt <= 8'h00;
      pwr_done <= 1'b0;
    end else begin
      mode <= next_mode;
      started <= next_started;
      edges <= next_edges;
      shreg <= next_shreg;
      so_oe <= next_so_oe;
      so_bit <= next_so_bit;
      tracking <= next_tracking;
      analog_on <= next_analog_on;
      result_valid <= next_result_valid;
      result_word <= next_result_word;
      was_down <= next_was_down;
      pwr_cnt <= next_pwr_cnt;
      pwr_done <= next_pwr_done;
    end
  end

  // Held low until the strap is taken, so a start in power-down never
  // shows powered for a cycle; high in waking mode only after the wait
  always_comb begin
    next_powered = started && ((mode == apm_pkg::APM_NORMAL) ||
      (mode == apm_pkg::APM_POWERING_UP && pwr_done));
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      powered <= 1'b0;
    end else begin
      powered <= next_powered;
    end
  end

  assign link.serial_out = so_bit;
  assign link.serial_out_oe = so_oe;
endmodule : apm_device

/* File: rtl/apm_host.sv */
`timescale 1ns/1ps
`include "apm_defs.svh"
module apm_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Link
  apm_link_if.host link,
  // User request
  input wire logic start,
  input wire logic [4:0] clocks,
  output logic busy,
  output logic done,
  output logic [15:0] rx_word
);
  apm_pkg::apm_host_state_t st, next_st;
  logic [7:0] div, next_div;
  logic [4:0] cnt, next_cnt, target, next_target;
  logic [7:0] qcnt, next_qcnt;
  logic cs_n, next_cs_n, sclk, next_sclk, next_busy, next_done;
  logic [15:0] next_rx_word;
  logic [2:0] so_s;

  // Data line is sampled through three stages from the far clock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      so_s <= 3'h0;
    end else begin
      so_s <= {so_s[1:0], link.serial_out & link.serial_out_oe};
    end
  end

  always_comb begin
    next_st = st;
    next_div = div;
    next_cnt = cnt;
    next_target = target;
    next_qcnt = qcnt;
    next_cs_n = cs_n;
    next_sclk = sclk;
    next_busy = busy;
    next_done = 1'b0;
    next_rx_word = rx_word;
    case (st)
      apm_pkg::APM_H_IDLE: begin
        if (start) begin
          // From 2 to 9 clocks means a power-down frame
          next_target = (clocks > 5'h10) ? 5'h10 : clocks;
          next_cs_n = 1'b0;
          next_busy = 1'b1;
          next_cnt = 5'h00;
          next_div = 8'h00;
          next_rx_word = 16'h0000;
          next_st = apm_pkg::APM_H_LEAD;
        end
      end
      apm_pkg::APM_H_LEAD, apm_pkg::APM_H_HIGH, apm_pkg::APM_H_LOW: begin
        if (div == `APM_SCLK_HALF) begin
          next_div = 8'h00;
          if (st == apm_pkg::APM_H_LOW) begin
            next_sclk = 1'b1;
            next_rx_word = {rx_word[14:0], so_s[2]};
            next_st = apm_pkg::APM_H_HIGH;
          end else if (cnt == target) begin
            next_cs_n = 1'b1;
            next_qcnt = 8'h00;
            next_st = apm_pkg::APM_H_QUIET;
          end else begin
            next_sclk = 1'b0;
            next_cnt = cnt + 5'h01;
            next_st = apm_pkg::APM_H_LOW;
          end
        end else begin
          next_div = div + 8'h01;
        end
      end
      apm_pkg::APM_H_QUIET: begin
        if (qcnt == 8'(`APM_QUIET_CYC) + 8'h04) begin
          next_busy = 1'b0;
          next_done = 1'b1;
          next_st = apm_pkg::APM_H_IDLE;
        end else begin
          next_qcnt = qcnt + 8'h01;
        end
      end
      default: next_st = apm_pkg::APM_H_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= apm_pkg::APM_H_IDLE;
      div <= 8'h00;
      cnt <= 5'h00;
      target <= 5'h00;
      qcnt <= 8'h00;
      cs_n <= 1'b1;
      sclk <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
      rx_word <= 16'h0000;
    end else begin
      st <= next_st;
      div <= next_div;
      cnt <= next_cnt;
      target <= next_target;
      qcnt <= next_qcnt;
      cs_n <= next_cs_n;
      sclk <= next_sclk;
      busy <= next_busy;
      done <= next_done;
      rx_word <= next_rx_word;
    end
  end

  assign link.cs_n = cs_n;
  assign link.sclk = sclk;
endmodule : apm_host

/* File: tb/apm_link_properties.sv */
`timescale 1ns/1ps
module apm_link_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic [4:0] falls;
  logic [4:0] next_falls;
  logic sclk_d;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Saturates so a runaway host cannot wrap back into the zero window
  always_comb begin
    next_falls = falls;
    if (cs_n) begin
      next_falls = 5'h00;
    end else if (sclk_d && !sclk && falls != 5'h1F) begin
      next_falls = falls + 5'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      falls <= 5'h00;
      sclk_d <= 1'b1;
    end else begin
      falls <= next_falls;
      sclk_d <= sclk;
    end
  end

  sequence s_select_fall;
    $fell(cs_n);
  endsequence
  sequence s_drive_on;
    ##[1:8] serial_out_oe;
  endsequence
  sequence s_quiet;
    cs_n [*6];
  endsequence

  a_select_drives: assert property (s_select_fall |-> s_drive_on)
    else $error("output not driven after select fall");
  // Only inside a frame: an aborted frame still shows its last bit for
  // the few cycles until the device sees select rise
  a_lead_zeros: assert property (!cs_n && falls < 5'h03
    && serial_out_oe |-> !serial_out) else $error("leading zero missing");
  a_bits_settle: assert property (sclk && $past(sclk)
    && serial_out_oe && $past(serial_out_oe) |-> $stable(serial_out))
    else $error("data moved while clock high");
  a_release_rise: assert property ($rose(cs_n)
    |-> ##[0:8] !serial_out_oe) else $error("output held after select rise");
  a_release_full: assert property ((falls == 5'h10)
    |-> ##[0:8] !serial_out_oe) else $error("output held after full frame");
  a_idle_released: assert property ((cs_n && !serial_out_oe)
    |=> !serial_out_oe) else $error("output driven while deselected");
  a_frame_len: assert property (falls <= 5'h10)
    else $error("more than sixteen falls in a frame");
  a_quiet_gap: assert property ($rose(cs_n) |-> s_quiet)
    else $error("select fell again too soon");
endmodule : apm_link_properties

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "apm_defs.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  error_cnt++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
  logic mclk;
  logic rst_n;
  logic [`APM_RES_W-1:0] sample;
  logic start_powered;
  logic powered;
  logic analog_on;
  logic tracking;
  logic result_valid;
  logic [`APM_RES_W-1:0] result_word;
  logic start;
  logic [4:0] clocks;
  logic busy;
  logic done;
  logic [15:0] rx_word;
  int error_cnt;
  int total_checks;
  int valid_cnt;
  int cyc;

  apm_link_if link();
  apm_device apm_device_i(.mclk(mclk), .rst_n(rst_n), .link(link),
    .sample(sample), .start_powered(start_powered), .powered(powered),
    .analog_on(analog_on), .tracking(tracking),
    .result_valid(result_valid), .result_word(result_word));
  apm_host apm_host_i(.mclk(mclk), .rst_n(rst_n), .link(link),
    .start(start), .clocks(clocks), .busy(busy), .done(done),
    .rx_word(rx_word));
  apm_link_properties apm_link_properties_i(.mclk(mclk), .rst_n(rst_n),
    .cs_n(link.cs_n), .sclk(link.sclk), .serial_out(link.serial_out),
    .serial_out_oe(link.serial_out_oe));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Whole run is a few thousand cycles; this only catches a hang
  always @(posedge mclk) begin
    cyc++;
    if (result_valid === 1'b1) valid_cnt++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic do_reset(input logic strap);
    start_powered <= strap;
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask : do_reset

  task automatic frame(input logic [4:0] n);
    @(posedge mclk);
    clocks <= n;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    for (int i = 0; i < 600 && done !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    // A hung frame shows up here rather than only at the global limit
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
  endtask : frame

  task automatic t_full(input logic [11:0] s);
    int v;
    v = valid_cnt;
    sample <= s;
    frame(5'h10);
    `CHK(rx_word, {4'h0, s})
    `CHK(result_word, s)
    `CHK(valid_cnt, v + 1)
    `CHK(powered, 1'b1)
  endtask : t_full

  task automatic t_keep;
    int v;
    v = valid_cnt;
    for (int k = 0; k < 4; k++) begin
      frame(k == 0 ? 5'h00 : k == 1 ? 5'h01 : k == 2 ? 5'h0A : 5'h0F);
      `CHK(powered, 1'b1)
      `CHK(analog_on, 1'b1)
    end
    `CHK(valid_cnt, v)
  endtask : t_keep

  task automatic t_down(input logic [4:0] n);
    frame(n);
    `CHK(powered, 1'b0)
    `CHK(analog_on, 1'b0)
    `CHK(tracking, 1'b0)
  endtask : t_down

  task automatic t_stay_down;
    for (int k = 0; k < 2; k++) begin
      frame(k == 0 ? 5'h01 : 5'h08);
      `CHK(powered, 1'b0)
      `CHK(analog_on, 1'b0)
    end
  endtask : t_stay_down

  task automatic t_wake(input logic [4:0] n);
    int v;
    v = valid_cnt;
    fork
      frame(n);
      begin
        wait (link.sclk === 1'b0);
        repeat (6) @(posedge mclk);
        `CHK(tracking, 1'b1)
      end
    join
    `CHK(valid_cnt, v)
    `CHK(powered, 1'b1)
    `CHK(analog_on, 1'b1)
  endtask : t_wake

  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    clocks = 5'h00;
    sample = 12'h000;
    start_powered = 1'b0;
    do_reset(1'b0);
    `CHK(powered, 1'b0)
    `CHK(tracking, 1'b1)
    t_wake(5'h10);
    t_full(12'h9C5);
    t_keep();
    t_down(5'h09);
    t_stay_down();
    t_wake(5'h0A);
    t_full(12'h3A7);
    t_down(5'h02);
    t_wake(5'h10);
    t_full(12'h801);
    do_reset(1'b1);
    `CHK(powered, 1'b1)
    t_full(12'h7FF);
    wrap_up();
  end
endmodule : tb_top
